// File: hw/iopc_pkg.sv
package iopc_pkg;
    localparam int PINS = 8;
    localparam int AW   = 6;
    // register byte addresses
    localparam logic [5:0] A_DIR     = 6'h00;
    localparam logic [5:0] A_DSET    = 6'h01;
    localparam logic [5:0] A_DCLR    = 6'h02;
    localparam logic [5:0] A_DTGL    = 6'h03;
    localparam logic [5:0] A_OUT     = 6'h04;
    localparam logic [5:0] A_LSET    = 6'h05;
    localparam logic [5:0] A_LCLR    = 6'h06;
    localparam logic [5:0] A_LTGL    = 6'h07;
    localparam logic [5:0] A_IN      = 6'h08;
    localparam logic [5:0] A_FLAGS   = 6'h09;
    localparam logic [5:0] A_MASK    = 6'h0A;
    localparam logic [5:0] A_CTRL0   = 6'h10;
    // bit-space alias block
    localparam logic [5:0] A_ALIAS   = 6'h20;
    localparam logic [5:0] A_ALIAS_M = 6'h3C;
    localparam logic [1:0] AL_DIR    = 2'h0;
    localparam logic [1:0] AL_OUT    = 2'h1;
    localparam logic [1:0] AL_IN     = 2'h2;
    localparam logic [1:0] AL_FLAGS  = 2'h3;
    // per_lead_setup fields
    localparam int F_SNS_LO = 0;
    localparam int F_PULL   = 3;
    localparam int F_INV    = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] ZERO8    = 8'h00;
    localparam logic [31:0] ZERO32  = 32'h0000_0000;
    typedef enum logic [2:0] {
        SNS_INTDIS  = 3'h0,
        SNS_BOTH    = 3'h1,
        SNS_RISE    = 3'h2,
        SNS_FALL    = 3'h3,
        SNS_OFF     = 3'h4,
        SNS_LEVEL   = 3'h5
    } iopc_snsmode_t;
endpackage

// File: hw/iopc_port.sv
`timescale 1ns/10ps
// Function
// RULE_01 - direction bit enables driver, level bit sets driven value
// RULE_02 - pad levels pass a two-stage synchroniser before being read
// RULE_03 - input-off sense mode stops clocking that pin's synchroniser
// RULE_04 - pin level readable whether pin is input or output
// RULE_05 - asynchronous change detection provides a clockless wake output; the wake port here is registered on clk
// RULE_06 - per pin sense on both, rising, falling edges or low level
// RULE_07 - direction change of one pin leaves other pins alone
// RULE_08 - set, clear and toggle strobes give hardware read-modify-write
// RULE_09 - every pin feeds its sensed condition to the port interrupt
// RULE_10 - pin events are delivered to the event fabric
// RULE_11 - alias register block writes act like the regular registers
// RULE_12 - per pin inversion of both paths and pull-up enable
// RULE_13 - pin setup gates other functions' input view and output drive
// RULE_14 - level set, clear, toggle strobes; writing one to input toggles
// RULE_15 - direction set, clear, toggle strobes act per bit only
// RULE_16 - inversion flips input and output; toggling it shows an edge
// RULE_17 - sense event sets flag; interrupt holds until flag cleared
// RULE_18 - direction and level bits reset to zero, pins are inputs
module iopc_port
    import iopc_pkg::*;
#(
    parameter int N = PINS
)(
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    input  wire logic          wr,
    input  wire logic          rd,
    output logic      [7:0]    rdata,
    input  wire logic [N-1:0]  pad_in,
    output logic      [N-1:0]  pad_out,
    output logic      [N-1:0]  pad_oe,
    output logic      [N-1:0]  pad_pullup,
    input  wire logic [N-1:0]  alt_out,
    input  wire logic [N-1:0]  alt_oe,
    output logic      [N-1:0]  alt_in,
    output logic      [N-1:0]  pin_event,
    output logic      [N-1:0]  wake,
    output logic               irq
);
    logic [N-1:0] dir;
    logic [N-1:0] outv;
    logic [N-1:0] flags;
    logic [N-1:0] mask;
    logic [7:0]   ctrl [N];
    logic [N-1:0] next_dir;
    logic [N-1:0] next_out;
    logic [N-1:0] wd;
    logic [N-1:0] inv;
    logic [N-1:0] pull;
    logic [N*3-1:0] smode_bus;
    logic         is_alias;
    logic [5:0]   eff_addr;

    iopc_sense_if #(.N(N)) sif ();
    iopc_sense #(.N(N)) u_sense (
        .clk  (clk),
        .nrst (nrst),
        .s    (sif)
    );

    assign wd = wdata[N-1:0];

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_cfg
            assign inv[g]  = ctrl[g][F_INV]; // RULE_12
            assign pull[g] = ctrl[g][F_PULL];
            assign smode_bus[g*3 +: 3] = ctrl[g][F_SNS_LO +: 3];
        end
    endgenerate
    assign sif.pad_in = pad_in;
    assign sif.inv    = inv;
    assign sif.smode  = smode_bus;

    // alias block maps dir/out/in/flags into a compact bit-space
    function automatic logic [5:0] map_addr(input logic [5:0] a);
        logic [5:0] r;
        r = a;
        if ((a & A_ALIAS_M) == A_ALIAS)
        begin
            unique case (a[1:0])
                AL_DIR:   r = A_DIR;
                AL_OUT:   r = A_OUT;
                AL_IN:    r = A_IN;
                AL_FLAGS: r = A_FLAGS;
            endcase
        end
        return r;
    endfunction
    assign eff_addr = map_addr(addr); // RULE_11
    assign is_alias = (addr & A_ALIAS_M) == A_ALIAS;

    always_comb
    begin
        next_dir = dir;
        if (wr)
        begin
            unique case (eff_addr)
                A_DIR:    next_dir = wd;
                A_DSET:   next_dir = dir | wd; // RULE_15
                A_DCLR:   next_dir = dir & ~wd; // RULE_07
                A_DTGL:   next_dir = dir ^ wd;
                default:  next_dir = dir;
            endcase
        end
    end

    always_comb
    begin
        next_out = outv;
        if (wr)
        begin
            unique case (eff_addr)
                A_OUT:    next_out = wd;
                A_LSET:   next_out = outv | wd; // RULE_14
                A_LCLR:   next_out = outv & ~wd; // RULE_08
                A_LTGL:   next_out = outv ^ wd;
                A_IN:     next_out = outv ^ wd;
                default:  next_out = outv;
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            dir  <= ZERO8[N-1:0]; // RULE_18
            outv <= ZERO8[N-1:0];
        end
        else
        begin
            dir  <= next_dir;
            outv <= next_out;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < N; i++)
                ctrl[i] <= CTRL_RST;
            mask <= ZERO8[N-1:0];
        end
        else if (wr && !is_alias)
        begin
            for (int i = 0; i < N; i++)
                if (addr == A_CTRL0 + 6'(i))
                    ctrl[i] <= wdata;
            if (addr == A_MASK)
                mask <= wd;
        end
    end

    // set beats clear; a read of flags or a write of ones clears
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            flags <= ZERO8[N-1:0];
        else
        begin
            logic [N-1:0] clr;
            clr = ZERO8[N-1:0];
            if (rd && eff_addr == A_FLAGS)
                clr = {N{1'b1}};
            if (wr && eff_addr == A_FLAGS)
                clr = wd;
            flags <= (flags & ~clr) | sif.hit; // RULE_17
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pad_out    <= ZERO8[N-1:0];
            pad_oe     <= ZERO8[N-1:0];
            pad_pullup <= ZERO8[N-1:0];
            alt_in     <= ZERO8[N-1:0];
            pin_event  <= ZERO8[N-1:0];
            wake       <= ZERO8[N-1:0];
            irq        <= 1'b0;
        end
        else
        begin
            // alternate function overrides only where it asks to drive
            pad_oe     <= next_dir | alt_oe; // RULE_01
            pad_out    <= ((alt_oe & alt_out) |
                           (~alt_oe & next_out)) ^ inv; // RULE_13
            pad_pullup <= pull;
            alt_in     <= sif.level;
            pin_event  <= sif.hit; // RULE_10
            // wake registered here; the raw sif.wake term does not leave the port
            wake       <= sif.wake; // RULE_05
            irq        <= |(((flags & ~(
                          (rd && eff_addr == A_FLAGS) ? {N{1'b1}} :
                          (wr && eff_addr == A_FLAGS) ? wd :
                          ZERO8[N-1:0])) | sif.hit) & mask); // RULE_09
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rdata <= ZERO8;
        else if (rd)
        begin
            rdata <= ZERO8;
            if (eff_addr == A_DIR)
                rdata[N-1:0] <= dir;
            else if (eff_addr == A_OUT)
                rdata[N-1:0] <= outv;
            else if (eff_addr == A_IN)
                rdata[N-1:0] <= sif.level; // RULE_04
            else if (eff_addr == A_FLAGS)
                rdata[N-1:0] <= flags;
            else if (eff_addr == A_MASK)
                rdata[N-1:0] <= mask;
            else
                for (int i = 0; i < N; i++)
                    if (addr == A_CTRL0 + 6'(i))
                        rdata <= ctrl[i];
        end
        else
            rdata <= ZERO8;
    end

    dir_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr && addr == A_DSET) |=> ((dir & $past(wd)) == $past(wd)))
        else $error("direction set strobe did not set bits"); // RULE_15
    dir_keep_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr && addr == A_DCLR) |=>
        ((dir & ~$past(wd)) == ($past(dir) & ~$past(wd))))
        else $error("direction clear disturbed other pins"); // RULE_07
    out_tgl_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr && (addr == A_LTGL || addr == A_IN)) |=>
        (outv == ($past(outv) ^ $past(wd))))
        else $error("toggle wrong"); // RULE_14
    out_clr_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr && addr == A_LCLR) |=> ((outv & $past(wd)) == ZERO8[N-1:0]))
        else $error("level clear wrong"); // RULE_08
    alias_out_a: assert property (@(posedge clk) disable iff (!nrst)
        (wr && addr == (A_ALIAS | 6'(AL_OUT))) |=> (outv == $past(wd)))
        else $error("alias write lost"); // RULE_11
    oe_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        (alt_oe == ZERO8[N-1:0]) |=> (pad_oe == dir))
        else $error("driver not following direction"); // RULE_01
    flag_set_a: assert property (@(posedge clk) disable iff (!nrst)
        (sif.hit != ZERO8[N-1:0]) |=> ((flags & $past(sif.hit))
        == $past(sif.hit)))
        else $error("event flag lost"); // RULE_17
    irq_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        ((flags & mask) != ZERO8[N-1:0] && !rd && !wr) |=> irq)
        else $error("irq dropped with flag set"); // RULE_09
    event_out_a: assert property (@(posedge clk) disable iff (!nrst)
        sif.hit[0] |=> pin_event[0])
        else $error("event not delivered"); // RULE_10

    irq_c:   cover property (@(posedge clk) disable iff (!nrst) $rose(irq));
    tgl_c:   cover property (@(posedge clk) disable iff (!nrst)
        wr && addr == A_LTGL);
    alias_c: cover property (@(posedge clk) disable iff (!nrst)
        wr && is_alias);
endmodule // iopc_port

// File: hw/iopc_sense.sv
`timescale 1ns/10ps
module iopc_sense
    import iopc_pkg::*;
#(
    parameter int N = PINS
)(
    input  wire logic   clk,
    input  wire logic   nrst,
    iopc_sense_if.sens  s
);
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] prev;

    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_pin
            logic [2:0] mode;
            logic       eff;
            assign mode = s.smode[g*3 +: 3];
            // inverted input path; flipping inv makes an edge
            assign eff  = sync2[g] ^ s.inv[g]; // RULE_16
            // synchroniser gated when input is off to save power
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    sync1[g] <= 1'b0;
                    sync2[g] <= 1'b0;
                    prev[g]  <= 1'b0;
                end
                else if (mode != SNS_OFF) // RULE_03
                begin
                    sync1[g] <= s.pad_in[g]; // RULE_02
                    sync2[g] <= sync1[g];
                    prev[g]  <= eff;
                end
            end
            assign s.level[g] = eff; // RULE_04
            always_comb
            begin
                unique case (mode)
                    SNS_BOTH:  s.hit[g] = eff ^ prev[g]; // RULE_06
                    SNS_RISE:  s.hit[g] = eff & ~prev[g];
                    SNS_FALL:  s.hit[g] = ~eff & prev[g];
                    SNS_LEVEL: s.hit[g] = ~eff;
                    default:   s.hit[g] = 1'b0;
                endcase
            end
            // clockless wake path: raw pad for both-edges/level
            assign s.wake[g] = ((mode == SNS_BOTH) &&
                                ((s.pad_in[g] ^ s.inv[g]) != prev[g])) ||
                               ((mode == SNS_LEVEL) &&
                                !(s.pad_in[g] ^ s.inv[g])); // RULE_05
        end
    endgenerate

    input_off_a: assert property (@(posedge clk) disable iff (!nrst)
        (s.smode[2:0] == SNS_OFF) |=> $stable(sync2[0]))
        else $error("synchroniser clocked while input off"); // RULE_03
endmodule // iopc_sense

// File: hw/iopc_sense_if.sv
`timescale 1ns/10ps
interface iopc_sense_if #(parameter int N = 8);
    logic [N-1:0] pad_in;
    logic [N-1:0] inv;
    logic [N*3-1:0] smode;
    logic [N-1:0] level;
    logic [N-1:0] hit;
    logic [N-1:0] wake;
    modport top  (output pad_in, output inv, output smode,
                  input level, input hit, input wake);
    modport sens (input pad_in, input inv, input smode,
                  output level, output hit, output wake);
endinterface

// File: test/iopc_pads.sv
`timescale 1ns/10ps
// pads beyond the port: an outside driver per pin, the weak pull-up,
// and a floating level that flips each cycle so it is never trusted
module iopc_pads
    import iopc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] pad_out,
    input  wire logic [7:0] pad_oe,
    input  wire logic [7:0] pad_pullup,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_lvl,
    output logic      [7:0] pad_in
);
    logic [7:0] last;

    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pad_oe[i])
                pad_in[i] = pad_out[i];
            else if (ext_en[i])
                pad_in[i] = ext_lvl[i];
            else if (pad_pullup[i])
                pad_in[i] = 1'b1;
            else
                pad_in[i] = ~last[i];
        end
    end

    always_ff @(posedge clk)
        last <= pad_in;
endmodule // iopc_pads

// File: test/tb.sv
`timescale 1ns/10ps
module tb;
    import iopc_pkg::*;
    logic          clk, nrst, wr, rd, irq;
    logic [AW-1:0] addr;
    logic [7:0]    wdata, rdata, pad_in, pad_out, pad_oe, pad_pullup;
    logic [7:0]    alt_out, alt_oe, alt_in, pin_event, wake;
    logic [7:0]    ext_en, ext_lvl, rv;
    int            n_fail, checks, cyc, ev_cnt, e0;
    iopc_snsmode_t md [6];

    iopc_port iopc_port_i (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
        .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
        .pin_event(pin_event), .wake(wake), .irq(irq));
    iopc_pads iopc_pads_i (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_lvl(ext_lvl),
        .pad_in(pad_in));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ceiling well above the few hundred cycles the scenarios need
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        ev_cnt <= ev_cnt + int'(pin_event[0]);
        if (cyc == 5000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("checks %0d, n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask

    task wait_n(input int n);
        repeat (n) @(posedge clk);
    endtask

    task wr_reg(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask

    task rd_reg(input logic [5:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 rv = rdata;
    endtask

    task t_reset();
        rd_reg(A_DIR);
        chk("dir", rv, 8'h00);
        rd_reg(A_OUT);
        chk("out", rv, 8'h00);
        chk("pad_oe", pad_oe, 8'h00);
    endtask

    task t_dir();
        wr_reg(A_DIR, 8'h0F);
        wr_reg(A_DSET, 8'h30);
        rd_reg(A_DIR);
        chk("dir", rv, 8'h3F);
        wr_reg(A_DCLR, 8'h01);
        wr_reg(A_DTGL, 8'h81);
        rd_reg(A_DIR);
        chk("dir", rv, 8'hBF);
        chk("pad_oe", pad_oe, 8'hBF);
    endtask

    task t_out();
        wr_reg(A_OUT, 8'h55);
        wr_reg(A_LSET, 8'h0A);
        wr_reg(A_LCLR, 8'h03);
        wr_reg(A_LTGL, 8'hFF);
        wr_reg(A_IN, 8'h01);
        chk("pad_out", pad_out, 8'hA2);
        wait_n(3);
        rd_reg(A_IN);
        chk("in", rv, (8'hA2 & 8'hBF) | (ext_lvl & ~8'hBF));
        wr_reg(A_ALIAS + {4'h0, AL_OUT}, 8'h0F);
        rd_reg(A_OUT);
        chk("out", rv, 8'h0F);
        rd_reg(A_ALIAS + {4'h0, AL_DIR});
        chk("alias dir", rv, 8'hBF);
        rd_reg(6'h0F);
        chk("unmapped", rv, 8'h00);
    endtask

    // one pad transition on pin 0, then irq, flag and event judged
    task phase(input logic lvl, input logic e, input logic ei);
        e0 = ev_cnt;
        @(posedge clk);
        ext_lvl[0] <= lvl;
        wait_n(6);
        #1 chk("irq", {7'h0, irq}, {7'h0, ei});
        rd_reg(A_FLAGS);
        chk("flags", rv, {7'h0, e});
        chk("event", {7'h0, ev_cnt != e0}, {7'h0, e});
    endtask

    task t_sense();
        logic [5:0] fe, re;
        fe = 6'b101010;
        re = 6'b100110;
        wr_reg(A_DIR, 8'h00);
        wr_reg(A_MASK, 8'h01);
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(A_CTRL0, {5'h00, md[i]});
            wait_n(6);
            rd_reg(A_FLAGS);
            phase(1'b0, fe[i], fe[i]);
            phase(1'b1, re[i], re[i]);
        end
        wr_reg(A_MASK, 8'h00);
        wr_reg(A_CTRL0, {5'h00, SNS_BOTH});
        wait_n(6);
        rd_reg(A_FLAGS);
        phase(1'b0, 1'b1, 1'b0);
    endtask

    task t_invert();
        @(posedge clk);
        ext_lvl[3] <= 1'b1;
        wr_reg(A_DIR, 8'h02);
        wr_reg(A_OUT, 8'h00);
        wr_reg(A_CTRL0 + 6'h01, 8'h88);
        wr_reg(A_CTRL0 + 6'h03, 8'h80);
        chk("pad_out1", {7'h0, pad_out[1]}, 8'h01);
        chk("pullup1", {7'h0, pad_pullup[1]}, 8'h01);
        wait_n(3);
        rd_reg(A_IN);
        chk("in inv", {6'h0, rv[3], rv[1]}, 8'h00);
        rd_reg(A_FLAGS);
        wr_reg(A_CTRL0, 8'h81);
        wait_n(6);
        rd_reg(A_FLAGS);
        chk("inv edge", rv, 8'h01);
    endtask

    task t_alt();
        @(posedge clk);
        alt_oe <= 8'h04;
        alt_out <= 8'h04;
        wait_n(2);
        #1 chk("alt drive", {6'h0, pad_oe[2], pad_out[2]}, 8'h03);
        wait_n(3);
        #1 chk("alt_in", {6'h0, alt_in[3], alt_in[2]}, 8'h01);
    endtask

    initial
    begin
        md = '{SNS_INTDIS, SNS_BOTH, SNS_RISE, SNS_FALL, SNS_OFF, SNS_LEVEL};
        nrst = 1'b0;
        {wr, rd} = 2'b00;
        addr = '0;
        wdata = 8'h00;
        alt_out = 8'h00;
        alt_oe = 8'h00;
        ext_en = 8'hFF;
        ext_lvl = 8'h41;
        n_fail = 0;
        checks = 0;
        cyc = 0;
        ev_cnt = 0;
        wait_n(2);
        nrst <= 1'b1;
        t_reset();
        t_dir();
        t_out();
        t_sense();
        t_invert();
        t_alt();
        end_of_test();
    end
endmodule // tb
